// ===== ext_pulse_src.sv
// Behavioural pulse source that drives the external count pin.
`timescale 1ns/10ps
module ext_pulse_src (
  input wire logic clk,
  input wire logic go,
  input wire logic [7:0] n_edges,
  input wire logic [3:0] half,
  output logic pin,
  output logic busy
);
  int i;
  int w;

  // Each level is held at least half clocks plus a random slack, so the
  // source can be quick or slow; the pin keeps its last driven level.
  initial begin
    pin = 1'b0;
    busy = 1'b0;
    forever begin
      @(posedge clk);
      if (go === 1'b1) begin
        busy <= 1'b1;
        for (i = 0; i < int'(n_edges); i++) begin
          w = int'(half) + int'($urandom % 3);
          repeat (w) @(posedge clk);
          pin <= ~pin;
        end
        repeat (int'(half)) @(posedge clk);
        busy <= 1'b0;
      end
    end
  end
endmodule : ext_pulse_src

// ===== shared_prescaler.sv
// Shared 8-bit prescaler that divides ticks for the timer or the watchdog.
`timescale 1ns/10ps
module shared_prescaler #(
  parameter int unsigned WIDTH = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic clear,
  input wire logic tick,
  input wire logic wdt_mode,
  input wire logic [2:0] rate_code,
  output logic out_pulse
);

  // The widest division is 1:256, so fewer bits cannot serve it.
  if (WIDTH != 8) begin : g_width_check
    $error("shared_prescaler WIDTH must be 8");
  end

  timer0_pkg::presc_state_t st;
  timer0_pkg::presc_state_t nxt;
  logic [3:0] shift;
  logic [WIDTH:0] lim;
  logic [WIDTH-1:0] mask;

  // Timer divides by two to the code plus one, watchdog by two to the code.
  assign shift = wdt_mode ? {1'b0, rate_code} : {1'b0, rate_code} + 4'h1;
  assign lim = {{WIDTH{1'b0}}, 1'b1} << shift;
  assign mask = lim[WIDTH-1:0] - {{(WIDTH-1){1'b0}}, 1'b1};

  // Software has no path to the count; only clear and tick move it.
  always_comb begin
    nxt = st;
    nxt.out = 1'b0;
    if (clear) begin
      nxt.count = '0;
    end else if (tick) begin
      nxt.count = st.count + 8'h01;
      nxt.out = ((st.count & mask) == mask);
    end
  end

  // State register.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else if (ce) begin
      st <= nxt;
    end
  end

  assign out_pulse = st.out;

endmodule : shared_prescaler

// ===== tb_timer0_with_shared_prescaler.sv
// Self-checking bench for the timer/counter block.
`timescale 1ns/10ps
module tb_timer0_with_shared_prescaler;
  `define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin \
    err_count++; $display("[ERR] %0t mismatch", $time); end end
  localparam logic [11:0] A_TMR = 12'h004, A_INT = 12'h02c;
  localparam logic [11:0] A_OPT = 12'h204, A_TRI = 12'h214;
  localparam logic [11:0] A_ANS = 12'h244, A_STA = 12'h300;
  localparam logic [11:0] A_MSK = 12'h304, A_BAD = 12'h3fc;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic [11:0] adr = 12'h000;
  logic [31:0] wdat = 32'h0;
  logic sleep = 1'b0;
  logic base = 1'b0;
  logic clr = 1'b0;
  logic go = 1'b0;
  logic [7:0] n_tg = 8'h00;
  logic [31:0] rdat;
  logic ack;
  logic pin;
  logic busy;
  logic wtick;
  logic irq;
  logic ok;
  logic [7:0] v;
  logic [15:0] exp_q[$];
  int err_count = 0;
  int cmp_count = 0;
  int wdt_cnt = 0;

  timer0_top DUT (
    .sys_clk(sys_clk), .reset_n(reset_n), .ce(1'b1),
    .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .external_count_pin(pin), .sleep_mode(sleep), .wdt_base_tick(base),
    .watchdog_clear_instruction(clr), .wdt_tick(wtick), .irq(irq)
  );
  ext_pulse_src SRC (
    .clk(sys_clk), .go(go), .n_edges(n_tg), .half(4'h3),
    .pin(pin), .busy(busy)
  );

  // Free-running clock at 4 ns.
  always #2 sys_clk = ~sys_clk;

  // Each read answer is matched against the oldest expected range.
  always @(posedge sys_clk) begin
    if (ack === 1'b1 && we === 1'b0) begin
      ok = rdat[7:0] >= exp_q[0][15:8] && rdat[7:0] <= exp_q[0][7:0];
      cmp_count++;
      if (ok !== 1'b1 || rdat[31:8] !== 24'h0) begin
        err_count++;
        $display("[ERR] %0t read %h", $time, rdat);
      end
      void'(exp_q.pop_front());
    end
    if (wtick === 1'b1) wdt_cnt++;
  end

  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : wt

  // The request is held until ack is seen, then one idle cycle follows.
  task automatic bus(input logic w, input logic [11:0] a,
                     input logic [7:0] d);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    do @(posedge sys_clk); while (ack !== 1'b1);
    cyc <= 1'b0;
    we <= 1'b0;
    @(posedge sys_clk);
  endtask : bus

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [7:0] lo,
                    input logic [7:0] hi);
    exp_q.push_back({lo, hi});
    bus(1'b0, a, 8'h00);
  endtask : rd

  task automatic tick_n(input int n);
    repeat (n) begin
      base <= 1'b1;
      @(posedge sys_clk);
      base <= 1'b0;
      wt(3);
    end
  endtask : tick_n

  task automatic clrw();
    clr <= 1'b1;
    @(posedge sys_clk);
    clr <= 1'b0;
    wt(2);
  endtask : clrw

  task automatic pins(input logic [7:0] n);
    n_tg <= n;
    go <= 1'b1;
    @(posedge sys_clk);
    go <= 1'b0;
    do @(posedge sys_clk); while (busy === 1'b1);
    wt(4);
  endtask : pins

  task automatic final_report();
    if (err_count == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : final_report

  // A hang is cut short well after the expected run length.
  initial begin
    #200us;
    err_count++;
    final_report();
  end

  // Main sequence: reset values, timer, watchdog, counter, interrupt.
  initial begin
    void'($urandom(32'ha83e));
    wt(2);
    reset_n <= 1'b1;
    wt(4);
    rd(A_TMR, 8'h00, 8'h00);
    rd(A_INT, 8'h00, 8'h00);
    rd(A_OPT, 8'hff, 8'hff);
    rd(A_BAD, 8'h00, 8'h00);
    wr(A_TRI, 8'hff);
    rd(A_TRI, 8'h3f, 8'h3f);
    wr(A_OPT, 8'hc8);
    wt(8);
    wr(A_TMR, 8'h20);
    wt(37);
    rd(A_TMR, 8'h27, 8'h28);
    sleep <= 1'b1;
    v = 8'($urandom);
    wr(A_TMR, v);
    wt(40);
    rd(A_TMR, v, v);
    sleep <= 1'b0;
    clrw();
    for (int r = 0; r < 8; r++) begin
      wr(A_OPT, 8'hc0 | 8'(r));
      wr(A_TMR, 8'h00);
      wt((24 << (r + 1)) - 3);
      rd(A_TMR, 8'h04, 8'h06);
    end
    tick_n(3);
    wt(2);
    `CHK(wdt_cnt, 3);
    clrw();
    wr(A_TMR, 8'h00);
    wr(A_OPT, 8'hca);
    tick_n(3);
    clrw();
    wdt_cnt = 0;
    tick_n(5);
    wt(2);
    `CHK(wdt_cnt, 1);
    wr(A_INT, 8'h00);
    wr(A_MSK, 8'h01);
    wr(A_OPT, 8'he8);
    wr(A_TMR, 8'hfe);
    wt(12);
    pins(8'd5);
    rd(A_TMR, 8'hfe, 8'hfe);
    wr(A_ANS, 8'h00);
    wt(8);
    wr(A_TMR, 8'hfe);
    wt(12);
    pins(8'd5);
    rd(A_TMR, 8'h00, 8'h00);
    rd(A_INT, 8'h04, 8'h04);
    `CHK(irq, 1'b0);
    wr(A_INT, 8'h24);
    wt(2);
    `CHK(irq, 1'b1);
    wr(A_MSK, 8'h00);
    wt(2);
    `CHK(irq, 1'b0);
    wr(A_MSK, 8'h01);
    wt(20);
    rd(A_INT, 8'h24, 8'h24);
    wr(A_STA, 8'h01);
    rd(A_INT, 8'h20, 8'h20);
    `CHK(irq, 1'b0);
    wr(A_INT, 8'h00);
    wr(A_OPT, 8'hf8);
    wt(8);
    wr(A_TMR, 8'h10);
    wt(12);
    pins(8'd7);
    rd(A_TMR, 8'h13, 8'h13);
    clrw();
    wr(A_OPT, 8'hf0);
    wt(8);
    wr(A_TMR, 8'h00);
    wt(12);
    pins(8'd8);
    rd(A_TMR, 8'h02, 8'h02);
    wt(4);
    final_report();
  end
endmodule : tb_timer0_with_shared_prescaler

// ===== timer0_pkg.sv
// Shared constants and types for the timer/counter block.
package timer0_pkg;

  // Bus geometry: registers sit at byte address four times their index.
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned IDX_W = ADDR_W - 2;

  // Register indices.
  localparam logic [IDX_W-1:0] IDX_TMR = 10'h001;
  localparam logic [IDX_W-1:0] IDX_INTC = 10'h00b;
  localparam logic [IDX_W-1:0] IDX_OPT = 10'h081;
  localparam logic [IDX_W-1:0] IDX_PORT_A_DIRECTION = 10'h085;
  localparam logic [IDX_W-1:0] IDX_ANALOG_PIN_SELECT = 10'h091;
  localparam logic [IDX_W-1:0] IDX_EVT_STAT = 10'h0c0;
  localparam logic [IDX_W-1:0] IDX_EVT_MASK = 10'h0c1;

  // Reset values.
  localparam logic [7:0] RST_TMR = 8'h00;
  localparam logic [7:0] RST_INTC = 8'h00;
  localparam logic [7:0] RST_OPT = 8'hff;
  localparam logic [7:0] RST_PORT_A_DIRECTION = 8'h3f;
  localparam logic [7:0] PORT_A_DIRECTION_IMPL = 8'h3f;
  localparam logic [7:0] RST_ANALOG_PIN_SELECT = 8'hff;
  // Folded pin level at reset: the analog pin reads low and the falling
  // edge is selected, so the edge history must start high.
  localparam logic RST_EXT_PREV = 1'b1;

  // Counter limits and the analog select bit of the count pin.
  localparam logic [7:0] CNT_MAX = 8'hff;
  localparam int unsigned EXT_ANALOG_PIN_SELECT_BIT = 2;
  localparam int unsigned EVT_OVF_BIT = 0;

  // Timing: an instruction cycle is four phases of the system clock.
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned TCY_NS = 16;
  localparam int unsigned PHASES = TCY_NS / CLK_PERIOD_NS;
  localparam logic [1:0] PH_Q2 = 2'h1;
  localparam logic [1:0] PH_Q4 = 2'h3;
  localparam logic [1:0] INHIBIT_TCY = 2'h2;

  // Option register layout.
  typedef struct packed {
    logic pull_dis;
    logic int_edge;
    logic cs;
    logic se;
    logic prescaler_assign;
    logic [2:0] rate;
  } option_t;

  // Interrupt control register layout.
  typedef struct packed {
    logic gie;
    logic peie;
    logic ovf_en;
    logic int_en;
    logic port_en;
    logic ovf_flag;
    logic int_flag;
    logic port_flag;
  } interrupt_control_t;

  // Whole state of the prescaler.
  typedef struct packed {
    logic [7:0] count;
    logic out;
  } presc_state_t;

  // Whole state of the timer top.
  typedef struct packed {
    logic [1:0] phase;
    logic [7:0] count;
    interrupt_control_t intc;
    option_t opt;
    logic [7:0] port_a_direction;
    logic [7:0] analog_pin_select;
    logic mask_ovf;
    logic [1:0] inhibit;
    logic ext_prev;
    logic ext_pend;
    logic ack;
    logic [31:0] rdata;
    logic irq;
    logic wdt_tick;
  } timer_state_t;

endpackage : timer0_pkg

// ===== timer0_top.sv
// Eight-bit timer/counter with shared prescaler and Wishbone registers.
// Overview of operation
// - Timer mode counts instruction cycles or prescaler output.
// - Counter write blocks increments for two cycles.
// - Counter mode counts external pin transitions.
// - Edge select: 0 rising, 1 falling.
// - Rollover to zero sets overflow flag.
// - Interrupt request only while overflow enable set.
// - Flag stays until cleared; clear before enabling.
// - Timer stops in sleep, no wake.
// - External input sampled on Q2 and Q4.
// - Assign bit: 0 timer, 1 watchdog.
// - Rate code sets timer and watchdog division.
// - Prescaler is eight bits, hidden from software.
// - Counter writes clear prescaler when timer-assigned.
// - Watchdog clear clears prescaler when watchdog-assigned.
// - Analog-configured count pin reads as zero.
`timescale 1ns/10ps
module timer0_top #(
  parameter int unsigned PRESC_W = 8
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [timer0_pkg::ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic external_count_pin,
  input wire logic sleep_mode,
  input wire logic wdt_base_tick,
  input wire logic watchdog_clear_instruction,
  output logic wdt_tick,
  output logic irq
);

  if (timer0_pkg::PHASES != 4) begin : g_phase_check
    $error("timer0_top expects four clock phases per cycle");
  end

  logic [1:0] rst_sync_ff;
  logic rst_n_int;
  timer0_pkg::timer_state_t st;
  timer0_pkg::timer_state_t nxt;

  // Reset enters asynchronously but is released through two flops.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_n_int = rst_sync_ff[1];

  // Bus decode: a request is taken once, in the cycle before ack.
  logic req;
  logic wr;
  logic [timer0_pkg::IDX_W-1:0] idx;
  logic wr_tmr;
  logic wr_intc;
  logic wr_opt;
  logic wr_port_a_direction;
  logic wr_analog_pin_select;
  logic wr_evt;
  logic wr_mask;
  assign req = wb_cyc_i & wb_stb_i & ~st.ack;
  assign wr = req & wb_we_i & wb_sel_i[0];
  assign idx = wb_adr_i[timer0_pkg::ADDR_W-1:2];
  assign wr_tmr = wr && (idx == timer0_pkg::IDX_TMR);
  assign wr_intc = wr && (idx == timer0_pkg::IDX_INTC);
  assign wr_opt = wr && (idx == timer0_pkg::IDX_OPT);
  assign wr_port_a_direction = wr && (idx == timer0_pkg::IDX_PORT_A_DIRECTION);
  assign wr_analog_pin_select = wr && (idx == timer0_pkg::IDX_ANALOG_PIN_SELECT);
  assign wr_evt = wr && (idx == timer0_pkg::IDX_EVT_STAT);
  assign wr_mask = wr && (idx == timer0_pkg::IDX_EVT_MASK);

  // Phase decode of the instruction cycle.
  logic tcy;
  logic sample;
  logic run;
  assign tcy = (st.phase == timer0_pkg::PH_Q4);
  assign sample = tcy || (st.phase == timer0_pkg::PH_Q2);
  assign run = ~sleep_mode;

  // The pin is masked while analog, then folded so one edge type counts.
  logic ext_level;
  logic ext_folded;
  logic ext_edge;
  assign ext_level = external_count_pin &
                     ~st.analog_pin_select[timer0_pkg::EXT_ANALOG_PIN_SELECT_BIT];
  assign ext_folded = ext_level ^ st.opt.se;
  assign ext_edge = ext_folded & ~st.ext_prev;

  // Prescaler routing: the assign bit picks its tick source and clear.
  logic src_pulse;
  logic pre_tick;
  logic pre_clear;
  logic pre_out;
  assign src_pulse = st.opt.cs ? ext_edge : tcy;
  assign pre_tick = st.opt.prescaler_assign ? wdt_base_tick
                               : (src_pulse & run);
  assign pre_clear = st.opt.prescaler_assign ? watchdog_clear_instruction
                                : wr_tmr;

  shared_prescaler #(
    .WIDTH(PRESC_W)
  ) u_presc (
    .clk(sys_clk),
    .rst_n(rst_n_int),
    .ce(ce),
    .clear(pre_clear),
    .tick(pre_tick),
    .wdt_mode(st.opt.prescaler_assign),
    .rate_code(st.opt.rate),
    .out_pulse(pre_out)
  );

  // Increment sources; external events only count at a phase sample.
  logic ext_event;
  logic inc_ext;
  logic inc_int;
  logic inc;
  logic overflow;
  assign ext_event = st.opt.prescaler_assign ? ext_edge : pre_out;
  assign inc_ext = st.opt.cs & sample & st.ext_pend;
  assign inc_int = ~st.opt.cs & (st.opt.prescaler_assign ? tcy : pre_out);
  assign inc = run & (st.inhibit == 2'h0) & (inc_ext | inc_int);
  assign overflow = inc & ~wr_tmr & (st.count == timer0_pkg::CNT_MAX);

  // Read multiplexer; unmapped indices read as zero.
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = 8'h00;
    case (idx)
      timer0_pkg::IDX_TMR: begin
        rd_byte = st.count;
      end
      timer0_pkg::IDX_INTC: begin
        rd_byte = st.intc;
      end
      timer0_pkg::IDX_OPT: begin
        rd_byte = st.opt;
      end
      timer0_pkg::IDX_PORT_A_DIRECTION: begin
        rd_byte = st.port_a_direction & timer0_pkg::PORT_A_DIRECTION_IMPL;
      end
      timer0_pkg::IDX_ANALOG_PIN_SELECT: begin
        rd_byte = st.analog_pin_select;
      end
      timer0_pkg::IDX_EVT_STAT: begin
        rd_byte = {7'h00, st.intc.ovf_flag};
      end
      timer0_pkg::IDX_EVT_MASK: begin
        rd_byte = {7'h00, st.mask_ovf};
      end
      default: begin
        rd_byte = 8'h00;
      end
    endcase
  end

  // Next-state logic for the whole block.
  always_comb begin
    nxt = st;
    nxt.phase = st.phase + 2'h1;
    nxt.ack = req;
    if (req) begin
      nxt.rdata = {24'h000000, rd_byte};
    end
    if (wr_opt) begin
      nxt.opt = timer0_pkg::option_t'(wb_dat_i[7:0]);
    end
    if (wr_port_a_direction) begin
      nxt.port_a_direction = wb_dat_i[7:0] & timer0_pkg::PORT_A_DIRECTION_IMPL;
    end
    if (wr_analog_pin_select) begin
      nxt.analog_pin_select = wb_dat_i[7:0];
    end
    if (wr_mask) begin
      nxt.mask_ovf = wb_dat_i[timer0_pkg::EVT_OVF_BIT];
    end
    // Edge history; a change of edge select may give one spurious edge.
    nxt.ext_prev = ext_folded;
    // A pending event that meets a new one at a sample stays pending.
    if (!st.opt.cs) begin
      nxt.ext_pend = 1'b0;
    end else if (run && ext_event) begin
      nxt.ext_pend = 1'b1;
    end else if (sample) begin
      nxt.ext_pend = 1'b0;
    end
    // Inhibit window is counted in whole instruction cycles.
    if (wr_tmr) begin
      nxt.inhibit = timer0_pkg::INHIBIT_TCY;
    end else if (tcy && (st.inhibit != 2'h0)) begin
      nxt.inhibit = st.inhibit - 2'h1;
    end
    // A write beats an increment in the same cycle.
    if (wr_tmr) begin
      nxt.count = wb_dat_i[7:0];
    end else if (inc) begin
      nxt.count = st.count + 8'h01;
    end
    // Software clears the flag by either view; a new overflow wins.
    if (wr_intc) begin
      nxt.intc = timer0_pkg::interrupt_control_t'(wb_dat_i[7:0]);
    end
    if (wr_evt && wb_dat_i[timer0_pkg::EVT_OVF_BIT]) begin
      nxt.intc.ovf_flag = 1'b0;
    end
    if (overflow) begin
      nxt.intc.ovf_flag = 1'b1;
    end
    nxt.irq = nxt.intc.ovf_flag & nxt.intc.ovf_en & nxt.mask_ovf;
    nxt.wdt_tick = st.opt.prescaler_assign ? pre_out : wdt_base_tick;
  end

  // State register, frozen while the clock enable is low.
  always_ff @(posedge sys_clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      st <= '0;
      st.count <= timer0_pkg::RST_TMR;
      st.intc <= timer0_pkg::RST_INTC;
      st.opt <= timer0_pkg::RST_OPT;
      st.port_a_direction <= timer0_pkg::RST_PORT_A_DIRECTION;
      st.analog_pin_select <= timer0_pkg::RST_ANALOG_PIN_SELECT;
      st.ext_prev <= timer0_pkg::RST_EXT_PREV;
    end else if (ce) begin
      st <= nxt;
    end
  end

  assign wb_dat_o = st.rdata;
  assign wb_ack_o = st.ack;
  assign wdt_tick = st.wdt_tick;
  assign irq = st.irq;

  // Checks; all but irq_gating_a, analog_zero_a and phase_sample_a apply only while the clock enable lets state move.
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n_int);

  sequence tmr_written;
    ce && wr_tmr;
  endsequence

  sequence held_count;
    ce && !wr_tmr && !$past(wr_tmr);
  endsequence

  ack_single_pulse_a: assert property (
    (ce && st.ack) |=> !st.ack)
    else $error("ack stayed high two cycles");

  overflow_sets_flag_a: assert property (
    (ce && inc && !wr_tmr && st.count == timer0_pkg::CNT_MAX)
      |=> (st.intc.ovf_flag && st.count == 8'h00))
    else $error("rollover did not set the flag");

  irq_gating_a: assert property (
    irq |-> (st.intc.ovf_flag && st.intc.ovf_en && st.mask_ovf))
    else $error("interrupt without enabled flag");

  flag_sticky_a: assert property (
    (ce && st.intc.ovf_flag && !wr_intc && !wr_evt)
      |=> st.intc.ovf_flag)
    else $error("overflow flag dropped by itself");

  write_inhibit_a: assert property (
    tmr_written |=> (st.count == $past(wb_dat_i[7:0]))
      ##1 (($stable(st.count) || !held_count) [*4]))
    else $error("count moved inside inhibit window");

  sleep_freeze_a: assert property (
    (ce && sleep_mode && !wr_tmr) |=> $stable(st.count))
    else $error("count moved during sleep");

  analog_zero_a: assert property (
    st.analog_pin_select[timer0_pkg::EXT_ANALOG_PIN_SELECT_BIT] |-> !ext_level)
    else $error("analog count pin read as one");

  direct_rate_a: assert property (
    (ce && !st.opt.cs && st.opt.prescaler_assign && tcy && run && !wr_tmr &&
     st.inhibit == 2'h0) |=> (st.count == $past(st.count) + 8'h01))
    else $error("unscaled timer missed an instruction cycle");

  phase_sample_a: assert property (
    inc_ext |-> (st.phase == timer0_pkg::PH_Q2 ||
                 st.phase == timer0_pkg::PH_Q4))
    else $error("external count taken off a sample phase");

endmodule : timer0_top
